/* File: bob_map.svh */
// Constants for the bit-operation and relative-jump decoder
`ifndef BOB_MAP_SVH
`define BOB_MAP_SVH

// Data path widths
`define BOB_INSTR_W      16
`define BOB_DATA_W       8
`define BOB_BANK_W       6
`define BOB_DADDR_W      14

// Instruction field positions
`define BOB_F_MSB        7
`define BOB_F_LSB        0
`define BOB_ACC_BIT      8
`define BOB_BIT_MSB      11
`define BOB_BIT_LSB      9
`define BOB_NIB_MSB      15
`define BOB_NIB_LSB      12
`define BOB_JMP_OPC_LSB  11
`define BOB_OFF_MSB      10
`define BOB_OFF_LSB      0

// Opcode values
`define BOB_OPC_SET      4'h8
`define BOB_OPC_TEST     4'hb
`define BOB_OPC_JUMP     5'h1a

// Access bank split and bank numbers of its two halves
`define BOB_IDX_LIMIT    8'h5f
`define BOB_ACC_LO_BANK  6'h00
`define BOB_ACC_HI_BANK  6'h3f

// Phases of one instruction cycle
`define BOB_Q1           2'h0
`define BOB_Q2           2'h1
`define BOB_Q3           2'h2
`define BOB_Q4           2'h3

// Flush lengths in instruction cycles
`define BOB_FLUSH_ONE    2'h1

`endif

/* File: bob_pkg.sv */
// Types shared by the decoder and its testbench
`include "bob_map.svh"
package bob_pkg;

    // Instruction kinds this block executes
    typedef enum logic [1:0] {
        kind_none,
        bit_set_file_op,
        bit_test_skip_clear_op,
        relative_jump_op
    } bob_kind_t;

    // Sequencer states
    typedef enum logic {
        st_exec,
        st_flush
    } bob_state_t;

    // Request towards the file register array
    typedef struct packed {
        logic [`BOB_DADDR_W-1:0] addr;
        logic                    rd;
        logic                    wr;
        logic [`BOB_DATA_W-1:0]  wdata;
    } bob_file_req_t;

endpackage

/* File: bob_addr_sel.sv */
// Resolves the 8-bit file field into a full data memory address
`timescale 1ns/1ns
`include "bob_map.svh"
module bob_addr_sel (
    // Operand fields
    input  wire logic [7:0]              f_addr,
    input  wire logic                    acc_bit,
    // Addressing context
    input  wire logic [`BOB_BANK_W-1:0]  bank_select_register,
    input  wire logic                    ext_set_en,
    input  wire logic [`BOB_DADDR_W-1:0] index_base,
    // Result
    output logic      [`BOB_DADDR_W-1:0] data_addr
);

    // Bank choice: indexed mode beats the access bank, banked mode uses the select value
    always_comb begin
        if (acc_bit) begin
            // Banked: select register supplies the upper bits
            data_addr = {bank_select_register, f_addr};
        end else if (ext_set_en && (f_addr <= `BOB_IDX_LIMIT)) begin
            // Indexed literal offset; wraps at the top of data memory
            data_addr = index_base + {{(`BOB_DADDR_W-8){1'b0}}, f_addr};
        end else if (f_addr <= `BOB_IDX_LIMIT) begin
            // Lower half of the access bank
            data_addr = {`BOB_ACC_LO_BANK, f_addr};
        end else begin
            // Upper half of the access bank maps onto the special registers
            data_addr = {`BOB_ACC_HI_BANK, f_addr};
        end
    end

endmodule

/* File: bob_decode.sv */
// Decode and execute of bit set, bit test-skip-if-clear and relative jump
`timescale 1ns/1ns
`include "bob_map.svh"
module bob_decode #(
    parameter int PC_W = 16                          // Program counter width, at least 12
) (
    // Clock and reset
    input  wire logic                    clk,
    input  wire logic                    rstn,
    // Instruction stream
    input  wire logic [`BOB_INSTR_W-1:0] instr_word,  // Word to execute, taken in Q1
    input  wire logic [1:0]              next_words,  // Length of the prefetched instruction
    input  wire logic [PC_W-1:0]         pc_inc,      // Program counter already advanced
    // Addressing context
    input  wire logic [`BOB_BANK_W-1:0]  bank_select_register,
    input  wire logic                    ext_set_en,
    input  wire logic [`BOB_DADDR_W-1:0] index_base,
    // File register port
    input  wire logic [`BOB_DATA_W-1:0]  file_rdata,  // Valid in Q2 of a read
    output bob_pkg::bob_file_req_t       file_req,
    // Program flow
    output logic                         pc_load,
    output logic      [PC_W-1:0]         pc_target,
    output logic                         idle_cycle,
    output logic      [1:0]              q_phase
);

    // Sign-extended, doubled jump displacement
    function automatic logic [PC_W-1:0] jump_disp(input logic [10:0] n);
        jump_disp = {{(PC_W-12){n[10]}}, n, 1'b0};
    endfunction

    // Single-bit mask from the three-bit index
    function automatic logic [`BOB_DATA_W-1:0] bit_mask(input logic [2:0] b);
        bit_mask = `BOB_DATA_W'(8'h01 << b);
    endfunction

    bob_pkg::bob_kind_t      kind_reg;        // Instruction in execution
    bob_pkg::bob_kind_t      kind_next;       // Decode of the incoming word
    bob_pkg::bob_state_t     state_reg;       // Executing or flushing
    bob_pkg::bob_state_t     state_next;      // State for the next instruction cycle
    bob_pkg::bob_file_req_t  file_req_reg;    // Registered file request
    logic [1:0]              q_reg;           // Current phase
    logic [2:0]              bit_reg;         // Bit index of the operation
    logic [10:0]             off_reg;         // Jump offset
    logic [`BOB_DATA_W-1:0]  data_reg;        // File value read in Q2
    logic                    skip_reg;        // Tested bit was clear
    logic [1:0]              flush_cnt_reg;   // Instruction cycles left to flush
    logic                    pc_load_reg;     // Program counter write strobe
    logic [PC_W-1:0]         pc_target_reg;   // Jump destination
    logic                    idle_reg;        // Current cycle is a flush
    logic [`BOB_DADDR_W-1:0] resolved_addr;   // Address of the incoming operand
    logic                    exec_q1;         // Decode slot of an executing cycle

    assign exec_q1 = (state_reg == bob_pkg::st_exec) && (q_reg == `BOB_Q1);

    // Operand address for the incoming word
    bob_addr_sel u_addr_sel (
        .f_addr               (instr_word[`BOB_F_MSB:`BOB_F_LSB]),
        .acc_bit              (instr_word[`BOB_ACC_BIT]),
        .bank_select_register (bank_select_register),
        .ext_set_en           (ext_set_en),
        .index_base           (index_base),
        .data_addr            (resolved_addr)
    );

    // Opcode decode; everything else is left to the rest of the core
    always_comb begin
        if (instr_word[`BOB_NIB_MSB:`BOB_NIB_LSB] == `BOB_OPC_SET) begin
            kind_next = bob_pkg::bit_set_file_op;
        end else if (instr_word[`BOB_NIB_MSB:`BOB_NIB_LSB] == `BOB_OPC_TEST) begin
            kind_next = bob_pkg::bit_test_skip_clear_op;
        end else if (instr_word[`BOB_NIB_MSB:`BOB_JMP_OPC_LSB] == `BOB_OPC_JUMP) begin
            kind_next = bob_pkg::relative_jump_op;
        end else begin
            kind_next = bob_pkg::kind_none;
        end
    end

    // Phase counter, free running from reset
    always_ff @(posedge clk) begin
        if (!rstn) begin
            q_reg <= `BOB_Q1;
        end else begin
            q_reg <= q_reg + 2'h1;
        end
    end

    // Instruction capture in Q1; flush cycles ignore the word on the bus
    always_ff @(posedge clk) begin
        if (!rstn) begin
            kind_reg <= bob_pkg::kind_none;
            bit_reg  <= 3'h0;
            off_reg  <= 11'h000;
        end else if (exec_q1) begin
            kind_reg <= kind_next;
            bit_reg  <= instr_word[`BOB_BIT_MSB:`BOB_BIT_LSB];
            off_reg  <= instr_word[`BOB_OFF_MSB:`BOB_OFF_LSB];
        end else if (q_reg == `BOB_Q1) begin
            kind_reg <= bob_pkg::kind_none;   // Idle cycle runs no operation
        end
    end

    // File port: read in Q2, write back in Q4 of the same instruction cycle
    always_ff @(posedge clk) begin
        if (!rstn) begin
            file_req_reg <= '0;
        end else begin
            case (q_reg)
                `BOB_Q1: begin
                    // Both bit instructions read the operand
                    file_req_reg.addr <= resolved_addr;
                    file_req_reg.rd   <= exec_q1 &&
                                         ((kind_next == bob_pkg::bit_set_file_op) ||
                                          (kind_next == bob_pkg::bit_test_skip_clear_op));
                end
                `BOB_Q2: begin
                    file_req_reg.rd <= 1'b0;
                end
                `BOB_Q3: begin
                    // Modify one bit only, rest of the byte passes through
                    file_req_reg.wr    <= (kind_reg == bob_pkg::bit_set_file_op);
                    file_req_reg.wdata <= data_reg | bit_mask(bit_reg);
                end
                `BOB_Q4: begin
                    file_req_reg.wr <= 1'b0;
                end
                default: begin
                    file_req_reg <= '0;
                end
            endcase
        end
    end

    // Operand capture at the end of Q2 and the bit test in Q3
    always_ff @(posedge clk) begin
        if (!rstn) begin
            data_reg <= '0;
            skip_reg <= 1'b0;
        end else begin
            if (q_reg == `BOB_Q2) begin
                data_reg <= file_rdata;
            end
            if (q_reg == `BOB_Q3) begin
                // Clear bit requests a skip; no flag is touched
                skip_reg <= (kind_reg == bob_pkg::bit_test_skip_clear_op) &&
                            !data_reg[bit_reg];
            end
        end
    end

    // Jump: target computed in Q3 and written in Q4 of the first cycle
    always_ff @(posedge clk) begin
        if (!rstn) begin
            pc_load_reg   <= 1'b0;
            pc_target_reg <= '0;
        end else if (q_reg == `BOB_Q3) begin
            pc_load_reg   <= (kind_reg == bob_pkg::relative_jump_op);
            pc_target_reg <= pc_inc + jump_disp(off_reg);
        end else begin
            pc_load_reg   <= 1'b0;
        end
    end

    // Next instruction cycle: jump and taken skip both flush the prefetch
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            bob_pkg::st_exec: begin
                if (kind_reg == bob_pkg::relative_jump_op || skip_reg) begin
                    state_next = bob_pkg::st_flush;
                end
            end
            bob_pkg::st_flush: begin
                if (flush_cnt_reg <= `BOB_FLUSH_ONE) begin
                    state_next = bob_pkg::st_exec;
                end
            end
            default: begin
                state_next = bob_pkg::st_exec;
            end
        endcase
    end

    // Sequencer advances once per instruction cycle, at the end of Q4
    always_ff @(posedge clk) begin
        if (!rstn) begin
            state_reg     <= bob_pkg::st_exec;
            flush_cnt_reg <= 2'h0;
            idle_reg      <= 1'b0;
        end else if (q_reg == `BOB_Q4) begin
            state_reg <= state_next;
            idle_reg  <= (state_next == bob_pkg::st_flush);
            if (state_reg == bob_pkg::st_exec) begin
                if (kind_reg == bob_pkg::relative_jump_op) begin
                    flush_cnt_reg <= `BOB_FLUSH_ONE;
                end else if (next_words == 2'h0) begin
                    flush_cnt_reg <= `BOB_FLUSH_ONE;   // Zero length treated as one word
                end else begin
                    flush_cnt_reg <= next_words;
                end
            end else begin
                flush_cnt_reg <= flush_cnt_reg - 2'h1;
            end
        end
    end

    // Outputs straight from flip-flops
    assign file_req   = file_req_reg;
    assign pc_load    = pc_load_reg;
    assign pc_target  = pc_target_reg;
    assign idle_cycle = idle_reg;
    assign q_phase    = q_reg;

    // Checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    property p_set_value;
        $rose(file_req_reg.wr) |->
            file_req_reg.wdata == ($past(file_rdata, 2) | bit_mask(bit_reg));
    endproperty
    a_set_value: assert property (p_set_value)
        else $error("bit set wrote a wrong value");

    property p_banked;
        exec_q1 && instr_word[`BOB_ACC_BIT] && kind_next != bob_pkg::kind_none |=>
            file_req_reg.addr[`BOB_DADDR_W-1:8] == $past(bank_select_register);
    endproperty
    a_banked: assert property (p_banked)
        else $error("banked operand address lacks the bank");

    property p_indexed;
        exec_q1 && !instr_word[`BOB_ACC_BIT] && ext_set_en &&
            instr_word[7:0] <= `BOB_IDX_LIMIT |=>
            file_req_reg.addr == $past(index_base) + {6'h00, $past(instr_word[7:0])};
    endproperty
    a_indexed: assert property (p_indexed)
        else $error("indexed literal offset address wrong");

    property p_skip_decision;
        (q_reg == `BOB_Q4) && (state_reg == bob_pkg::st_exec) &&
            (kind_reg == bob_pkg::bit_test_skip_clear_op) |=> idle_reg == $past(skip_reg);
    endproperty
    a_skip_decision: assert property (p_skip_decision)
        else $error("skip taken against the tested bit");

    property p_one_word_flush;
        $rose(idle_reg) && flush_cnt_reg == 2'h1 |-> idle_reg [*4] ##1 !idle_reg;
    endproperty
    a_one_word_flush: assert property (p_one_word_flush)
        else $error("single flush cycle has wrong length");

    property p_two_word_flush;
        $rose(idle_reg) && flush_cnt_reg == 2'h2 |-> idle_reg [*8] ##1 !idle_reg;
    endproperty
    a_two_word_flush: assert property (p_two_word_flush)
        else $error("two-word flush has wrong length");

    property p_jump_q4;
        pc_load_reg |-> q_reg == `BOB_Q4 ##1 idle_reg;
    endproperty
    a_jump_q4: assert property (p_jump_q4)
        else $error("program counter write outside Q4 or no idle cycle");

    property p_jump_target;
        $rose(pc_load_reg) |-> pc_target_reg == $past(pc_inc) + jump_disp(off_reg);
    endproperty
    a_jump_target: assert property (p_jump_target)
        else $error("jump target wrong");

    property p_jump_two_cycles;
        $rose(pc_load_reg) |=> idle_reg [*4] ##1 !idle_reg;
    endproperty
    a_jump_two_cycles: assert property (p_jump_two_cycles)
        else $error("jump did not take two instruction cycles");

    property p_set_one_cycle;
        $rose(file_req_reg.rd) && kind_reg == bob_pkg::bit_set_file_op |->
            ##2 file_req_reg.wr && file_req_reg.addr == $past(file_req_reg.addr, 2);
    endproperty
    a_set_one_cycle: assert property (p_set_one_cycle)
        else $error("bit set write-back not in Q4 of same cycle");

endmodule

/* File: test_bit_op_branch_decode.sv */
// Self-checking testbench for the bit-operation and relative-jump decoder
`timescale 1ns/1ns
module test_bit_op_branch_decode;
    localparam int PC_W = 16;                       // Program counter width under test
    // File fields of the bit-set sweep: both access halves and both sides of the split
    localparam logic [7:0]  f_tab [8] = '{8'h00, 8'h5f, 8'h60, 8'hff, 8'h5f, 8'h60, 8'h10, 8'ha3};
    // Jump offsets: both range ends, zero and minus one
    localparam logic [10:0] n_tab [4] = '{11'h3ff, 11'h400, 11'h000, 11'h7ff};
    // Unknown opcodes, including near misses of the jump and test codes
    localparam logic [15:0] bad_tab [4] = '{16'h0000, 16'h9e55, 16'hd800, 16'ha2ff};

    // Clock and reset
    logic                   clk;
    logic                   rstn;
    // Stimulus, all driven on the falling edge
    logic [15:0]            instr_word;
    logic [1:0]             next_words;
    logic [PC_W-1:0]        pc_inc;
    logic [5:0]             bank_select_register;
    logic                   ext_set_en;
    logic [13:0]            index_base;
    logic [7:0]             file_rdata;
    // Observed outputs
    bob_pkg::bob_file_req_t freq;
    logic                   pc_load;
    logic [PC_W-1:0]        pc_target;
    logic                   idle_cycle;
    logic [1:0]             q_phase;
    // Bookkeeping
    int                     num_errors;
    int                     n_compared;
    int                     cycles;

    bob_decode #(.PC_W(PC_W)) i_dut (
        .clk                  (clk),
        .rstn                 (rstn),
        .instr_word           (instr_word),
        .next_words           (next_words),
        .pc_inc               (pc_inc),
        .bank_select_register (bank_select_register),
        .ext_set_en           (ext_set_en),
        .index_base           (index_base),
        .file_rdata           (file_rdata),
        .file_req             (freq),
        .pc_load              (pc_load),
        .pc_target            (pc_target),
        .idle_cycle           (idle_cycle),
        .q_phase              (q_phase)
    );

    // 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Hang guard: the whole run needs well under a thousand clocks
    always @(posedge clk) begin
        cycles = cycles + 1;
        if (cycles == 3000) begin
            num_errors = num_errors + 1;
            close_out();
        end
    end

    // Verdict and end of run
    task automatic close_out();
        $display("Counts: %0d compared, %0d mismatches", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Compare seen against expected, four-state exact
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared = n_compared + 1;
        if (seen !== exp) begin
            num_errors = num_errors + 1;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Expected data address from the current addressing context
    function automatic logic [13:0] exp_addr(input logic [7:0] f, input logic a);
        if (a) return {bank_select_register, f};
        if (ext_set_en && f <= 8'h5f) return index_base + {6'h00, f};
        if (f <= 8'h5f) return {6'h00, f};
        return {6'h3f, f};
    endfunction

    // One instruction: called at a falling edge in Q1, returns at the next free Q1
    task automatic op(input logic [15:0] w, input logic [7:0] v, input logic [1:0] nw,
                      input logic [15:0] pc, input logic xrd, input logic [13:0] xa,
                      input logic xwr, input logic [7:0] xwd, input logic xpl,
                      input logic [15:0] xtg, input int xidle);
        int n;
        instr_word = w;
        file_rdata = v;
        next_words = nw;
        pc_inc     = pc;
        @(negedge clk);
        instr_word = 16'h0000;                              // Nothing left to take
        check(32'(q_phase), 32'h1);
        check(32'(freq.rd), 32'(xrd));
        if (xrd) check(32'(freq.addr), 32'(xa));
        @(negedge clk);
        check(32'(freq.rd), 32'h0);
        @(negedge clk);
        check(32'(freq.wr), 32'(xwr));
        if (xwr) check(32'(freq.wdata), 32'(xwd));
        if (xrd) check(32'(freq.addr), 32'(xa));
        check(32'(pc_load), 32'(xpl));
        if (xpl) check(32'(pc_target), 32'(xtg));
        @(negedge clk);
        check(32'(freq.wr), 32'h0);
        check(32'(pc_load), 32'h0);
        // A set word offered during a flush must be ignored
        if (xidle > 0) instr_word = 16'h8e00;
        n = 0;
        while (idle_cycle === 1'b1 && n < 16) begin
            check(32'(freq.rd), 32'h0);
            n = n + 1;
            @(negedge clk);
            if (n == 1) instr_word = 16'h0000;
        end
        check(32'(n), 32'(4 * xidle));
        check(32'(q_phase), 32'h0);
    endtask

    // Bit set over every bit index and every addressing case
    task automatic t_set();
        logic [2:0] b;
        logic       a;
        logic [7:0] f;
        logic [7:0] v;
        for (int i = 0; i < 8; i++) begin
            b = 3'(i);
            a = (i == 3 || i == 7);
            f = f_tab[i];
            v = (i == 2) ? 8'h04 : 8'h0a;                   // Bit already set here, and for i 1 and 3 by 8'h0a
            ext_set_en = (i >= 4);
            op({4'h8, b, a, f}, v, 2'h1, 16'h0000, 1'b1, exp_addr(f, a), 1'b1,
               v | (8'h01 << b), 1'b0, 16'h0000, 0);
        end
        $display("test bit_set done");
    endtask

    // Test-skip with every prefetched length, then a no-skip case back to back
    task automatic t_test();
        logic [2:0] b;
        logic [7:0] f;
        for (int k = 0; k < 4; k++) begin
            b = 3'(2 * k + 1);
            f = 8'h40 + 8'(k);
            op({4'hb, b, 1'b0, f}, ~(8'h01 << b), 2'(k), 16'h0000, 1'b1, exp_addr(f, 1'b0),
               1'b0, 8'h00, 1'b0, 16'h0000, (k == 0) ? 1 : k);
        end
        op({4'hb, 3'h5, 1'b1, 8'h77}, 8'h20, 2'h3, 16'h0000, 1'b1, exp_addr(8'h77, 1'b1),
           1'b0, 8'h00, 1'b0, 16'h0000, 0);
        $display("test bit_test_skip done");
    endtask

    // Relative jump at both offset limits, zero, minus one and a wrapping PC
    task automatic t_jump();
        logic [10:0] n;
        logic [15:0] pc;
        for (int k = 0; k < 4; k++) begin
            n  = n_tab[k];
            pc = (k == 0) ? 16'hfff0 : 16'h0800;
            op({5'h1a, n}, 8'h00, 2'h1, pc, 1'b0, 14'h0000, 1'b0, 8'h00, 1'b1,
               pc + {{4{n[10]}}, n, 1'b0}, 1);
        end
        $display("test relative_jump done");
    endtask

    // Unknown opcodes do nothing; reset in mid jump clears everything
    task automatic t_misc();
        for (int k = 0; k < 4; k++) begin
            op(bad_tab[k], 8'hff, 2'h1, 16'h0000, 1'b0, 14'h0000, 1'b0, 8'h00, 1'b0,
               16'h0000, 0);
        end
        instr_word = {5'h1a, 11'h005};
        @(negedge clk);
        rstn       = 1'b0;
        instr_word = 16'h0000;
        repeat (2) @(negedge clk);
        check(32'(q_phase), 32'h0);
        check(32'(pc_load), 32'h0);
        check(32'(idle_cycle), 32'h0);
        check(32'(freq), 32'h0);
        rstn = 1'b1;
        op({4'h8, 3'h0, 1'b1, 8'h12}, 8'hf0, 2'h1, 16'h0000, 1'b1, exp_addr(8'h12, 1'b1),
           1'b1, 8'hf1, 1'b0, 16'h0000, 0);
        $display("test misc_reset done");
    endtask

    // Main sequence
    initial begin
        num_errors           = 0;
        n_compared           = 0;
        cycles               = 0;
        rstn                 = 1'b0;
        instr_word           = 16'h0000;
        next_words           = 2'h1;
        pc_inc               = 16'h0000;
        bank_select_register = 6'h15;
        ext_set_en           = 1'b0;
        index_base           = 14'h3fd0;                    // Makes indexed sums wrap
        file_rdata           = 8'h00;
        repeat (5) @(negedge clk);
        rstn = 1'b1;
        t_set();
        t_test();
        t_jump();
        t_misc();
        close_out();
    end
endmodule
